/* File: logic/olss_pkg.sv */
// Constants and types shared by the sequencer files
package olss_pkg;
    // Instruction opcodes (illustrative values)
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_OTP_PROGRAM = 8'h42;
    localparam logic [7:0] OP_LOCK_WRITE = 8'hE5;
    localparam logic [7:0] OP_SMALL_ERASE = 8'h20;
    // OTP geometry
    localparam int OTP_BYTES = 65;
    localparam int OTP_DATA_BYTES = 64;
    localparam int OTP_AW = 7;
    localparam int OTP_CTRL_IDX = 64;
    localparam int OTP_LOCK_BIT = 0;
    // Lock byte fields
    localparam int LOCK_WR_BIT = 0;
    localparam int LOCK_DOWN_BIT = 1;
    localparam logic [1:0] LOCK_RESET = 2'h0;
    // Address fields
    localparam int ADDR_W = 22;
    localparam int SECTOR_LSB = 16;
    localparam int SECTOR_W = 6;
    localparam int SUBSECT_LSB = 12;
    localparam int SUBSECT_W = 10;
    localparam logic [2:0] BP_RESET = 3'h0;
    // Timing
    localparam int CLK_MHZ = 40;
    localparam int PP_TIME_US = 5000;
    localparam int SSE_TIME_US = 150000;
    localparam int PP_CYCLES = PP_TIME_US * CLK_MHZ;
    localparam int SSE_CYCLES = SSE_TIME_US * CLK_MHZ;
    // Decoded frame kinds; unused, as the link hands raw opcodes to the core
    typedef enum logic [2:0] {
        OLSS_CMD_NONE,
        OLSS_CMD_WRITE_ENABLE_INSTR,
        OLSS_CMD_OTP,
        OLSS_CMD_LOCK,
        OLSS_CMD_ERASE
    } olss_cmd_t;
endpackage

/* File: logic/olss_link_rx.sv */
`timescale 1ns/1ps
// Serial-clock side: shifts in frames and snapshots the bit count at select rise
module olss_link_rx (
    // Link clock and pins
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_serial_in_pin,
    // Frame results, held until the next frame overwrites them
    output logic [7:0] o_opcode,
    output logic [23:0] o_addr,
    output logic [7:0] o_first_data,
    output logic [15:0] o_bit_count,
    output logic o_frame_tgl,
    // OTP byte writes, toggle per byte
    output logic [7:0] o_byte,
    output logic [6:0] o_byte_idx,
    output logic o_byte_tgl
);
    import olss_pkg::*;
    logic [15:0] cnt_q;
    logic [7:0] sh_q;
    // Toggles start defined: no reset reaches the serial clock domain
    logic ftgl_q = 1'b0;
    logic btgl_q = 1'b0;

    // Bit counter restarts with select; sclk only runs inside frames
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            cnt_q <= 16'h0000;
            sh_q <= 8'h00;
        end else begin
            sh_q <= {sh_q[6:0], i_serial_in_pin};
            if (cnt_q != 16'hFFFF) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    // Capture fields as bytes complete
    always_ff @(posedge i_sclk) begin
        if (!i_cs_n) begin
            if (cnt_q == 16'd7) o_opcode <= {sh_q[6:0], i_serial_in_pin};
            if (cnt_q[15:3] >= 13'd1 && cnt_q[15:3] <= 13'd3
                && cnt_q[2:0] == 3'h7) begin
                o_addr <= {o_addr[15:0], sh_q[6:0], i_serial_in_pin};
            end
            if (cnt_q == 16'd39) o_first_data <= {sh_q[6:0], i_serial_in_pin};
            // Bytes past the 65th are dropped, no wrap
            if (cnt_q[2:0] == 3'h7 && cnt_q[15:3] >= 13'd4
                && cnt_q[15:3] < 13'd4 + 13'(OTP_BYTES)) begin
                o_byte <= {sh_q[6:0], i_serial_in_pin};
                o_byte_idx <= 7'(cnt_q[15:3] - 13'd4);
                btgl_q <= ~btgl_q;
            end
        end
    end

    // Frame end: count snapshot on select rise, then toggle
    always_ff @(posedge i_cs_n) begin
        o_bit_count <= cnt_q;
        ftgl_q <= ~ftgl_q;
    end
    assign o_frame_tgl = ftgl_q;
    assign o_byte_tgl = btgl_q;
endmodule

/* File: logic/olss_otp_array.sv */
`timescale 1ns/1ps
// OTP storage: 64 data bytes plus control byte, one-to-zero only
module olss_otp_array #(
    parameter int DEPTH = 65
) (
    // Clock and control
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    // Program port
    input wire logic i_prog,
    input wire logic [6:0] i_idx,
    input wire logic [7:0] i_data,
    // Read and lock state
    input wire logic [6:0] i_rd_idx,
    output logic [7:0] o_rd_data,
    output logic o_locked
);
    import olss_pkg::*;
    logic [7:0] mem_q [DEPTH];
    logic [7:0] mem_d [DEPTH];

    // Programming ANDs in data so a zero never returns
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (i_prog && int'(i_idx) < DEPTH) begin
            mem_d[i_idx] = mem_q[i_idx] & i_data;
        end
    end

    // Erased state models a fresh part; reset is power-up
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (i_reset) begin
                mem_q[i] <= 8'hFF;
            end else if (i_ce) begin
                mem_q[i] <= mem_d[i];
            end
        end
    end

    assign o_locked = ~mem_q[OTP_CTRL_IDX][OTP_LOCK_BIT];
    always_ff @(posedge i_clk) begin
        o_rd_data <= (int'(i_rd_idx) < DEPTH) ? mem_q[i_rd_idx] : 8'hFF;
    end
endmodule

/* File: logic/olss_sequencer.sv */
`timescale 1ns/1ps
// OTP program, lock byte write and small block erase sequencer
module olss_sequencer
    import olss_pkg::*;
#(
    parameter int PP_CNT = olss_pkg::PP_CYCLES,
    parameter int SSE_CNT = olss_pkg::SSE_CYCLES,
    parameter int SECTORS = 64
) (
    // System clock
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    // Serial link pins
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_serial_in_pin,
    // Hardware block protection
    input wire logic [2:0] i_block_protect_bits,
    // Status
    output logic o_write_in_progress_flag,
    output logic o_write_enable_latch,
    output logic o_otp_locked,
    // Erase request to the array
    output logic o_erase_start,
    output logic [olss_pkg::SUBSECT_W-1:0] o_erase_subsector,
    // Lock byte readback for a chosen sector
    input wire logic [olss_pkg::SECTOR_W-1:0] i_lock_rd_sector,
    output logic [7:0] o_sector_lock_byte,
    // OTP readback
    input wire logic [6:0] i_otp_rd_idx,
    output logic [7:0] o_otp_rd_data
);
    import olss_pkg::*;

    // Idle, or which self-timed cycle is running
    typedef enum {OLSS_IDLE, OLSS_OTP, OLSS_ERASE} olss_state_t;

    // Timer width covers the longest cycle count at this clock
    localparam int CW = 28;

    // Link-domain frame data
    logic [7:0] l_opcode;
    logic [23:0] l_addr;
    logic [7:0] l_first;
    logic [15:0] l_bits;
    logic l_frame_tgl;
    logic [7:0] l_byte;
    logic [6:0] l_idx;
    logic l_byte_tgl;

    // Link logic runs on the serial clock; only held results cross, and
    // each is read here only after its toggle has been synchronised
    olss_link_rx u_rx (
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_serial_in_pin(i_serial_in_pin),
        .o_opcode(l_opcode),
        .o_addr(l_addr),
        .o_first_data(l_first),
        .o_bit_count(l_bits),
        .o_frame_tgl(l_frame_tgl),
        .o_byte(l_byte),
        .o_byte_idx(l_idx),
        .o_byte_tgl(l_byte_tgl)
    );

    // Toggle synchronisers; data held stable well past the toggle
    // Block protect bits are pin levels, so they pass two flops too
    logic [2:0] ftg_q;
    logic [2:0] btg_q;
    logic [2:0] bp_s1_q;
    logic [2:0] bp_q;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ftg_q <= 3'h0;
            btg_q <= 3'h0;
            bp_s1_q <= BP_RESET;
            bp_q <= BP_RESET;
        end else if (i_ce) begin
            ftg_q <= {ftg_q[1:0], l_frame_tgl};
            btg_q <= {btg_q[1:0], l_byte_tgl};
            bp_s1_q <= i_block_protect_bits;
            bp_q <= bp_s1_q;
        end
    end

    // One-cycle events when a synchronised toggle changes level
    logic frame_ev;
    logic byte_ev;
    assign frame_ev = ftg_q[2] ^ ftg_q[1];
    assign byte_ev = btg_q[2] ^ btg_q[1];

    // OTP bytes are staged, then committed only on a valid frame end
    logic [7:0] stage_q [OTP_BYTES];
    logic [OTP_BYTES-1:0] svalid_q;
    logic [OTP_BYTES-1:0] svalid_d;
    // Write strobe from the synchronised byte event only; the raw select
    // pin belongs to the other clock and is never read here
    logic stage_we;
    assign stage_we = i_ce && byte_ev;
    always_ff @(posedge i_clk) begin
        if (stage_we) begin
            stage_q[l_idx] <= l_byte;
        end
    end

    // Sequencer state
    olss_state_t st_q, st_d;
    logic [CW-1:0] tmr_q, tmr_d;
    logic wel_q, wel_d;
    logic [6:0] pidx_q, pidx_d;
    // OTP start offset from the low address bits; upper bits ignored
    logic [6:0] pbase_q, pbase_d;
    logic [7:0] ptgt;
    logic [1:0] lock_q [SECTORS];
    logic [1:0] lock_d [SECTORS];
    logic erase_d;
    logic [SUBSECT_W-1:0] esub_q, esub_d;
    logic prog;
    logic otp_locked;

    // Frame decode
    // Sector field skips the top two address bits
    logic busy;
    logic [SECTOR_W-1:0] sect;
    logic bp_hit;
    logic [5:0] prot_top;
    assign busy = (st_q != OLSS_IDLE);
    assign sect = l_addr[SECTOR_LSB +: SECTOR_W];

    // Wide sum so a target past the control byte shows up, never wraps
    assign ptgt = {1'b0, pbase_q} + {1'b0, pidx_q};

    // Upper sectors protected by block protect count, power-of-two sizes;
    // all ones protects everything, which the shift alone cannot express
    assign prot_top = (bp_q == 3'h0) ? 6'h00 :
        6'(64 >> (3'h7 - bp_q));
    assign bp_hit = (bp_q != 3'h0) && (sect >= 6'(64 - int'(prot_top)))
        || (bp_q == 3'h7);


    // Next values; frames are decoded only while idle, but a frame during a
    // running cycle still restages bytes and clears the valid bits it programs from
    always_comb begin
        st_d = st_q;
        pbase_d = pbase_q;
        tmr_d = tmr_q;
        wel_d = wel_q;
        pidx_d = pidx_q;
        svalid_d = svalid_q;
        erase_d = 1'b0;
        esub_d = esub_q;
        prog = 1'b0;
        for (int s = 0; s < SECTORS; s++) begin
            lock_d[s] = lock_q[s];
        end
        if (byte_ev) begin
            svalid_d[l_idx] = 1'b1;
        end
        if (frame_ev) begin
            // Every frame end clears the staged valid bits; an accepted program keeps them
            svalid_d = '0;
            // Any frame while a cycle runs is left undecoded
            if (!busy) begin
                // Write enable is exactly one opcode byte
                if (l_bits == 16'd8 && l_opcode == OP_WRITE_ENABLE) begin
                    wel_d = 1'b1;
                end
                // Select rise on a byte boundary with data
                if (wel_q && l_opcode == OP_OTP_PROGRAM
                    && l_bits >= 16'd40 && l_bits[2:0] == 3'h0
                    && !otp_locked) begin
                    st_d = OLSS_OTP;
                    tmr_d = CW'(PP_CNT);
                    // OTP start index from low seven address bits
                    pbase_d = l_addr[OTP_AW-1:0];
                    pidx_d = 7'h00;
                    svalid_d = svalid_q;
                end
                if (wel_q && l_opcode == OP_LOCK_WRITE
                    && l_bits == 16'd40) begin
                    // Volatile bits: no timed cycle, so busy never rises
                    // Frozen once lock-down set
                    if (!lock_q[sect][LOCK_DOWN_BIT]) begin
                        lock_d[sect] = {l_first[LOCK_DOWN_BIT],
                            l_first[LOCK_WR_BIT]};
                    end
                    wel_d = 1'b0;
                end
                if (wel_q && l_opcode == OP_SMALL_ERASE
                    && l_bits == 16'd32) begin
                    if (!bp_hit && !lock_q[sect][LOCK_WR_BIT]) begin
                        st_d = OLSS_ERASE;
                        tmr_d = CW'(SSE_CNT);
                        // Start pulse and subsector go out alongside busy
                        erase_d = 1'b1;
                        esub_d = l_addr[SUBSECT_LSB +: SUBSECT_W];
                    end else begin
                        // An erase refused by protection or a sector lock still drops the latch
                        wel_d = 1'b0;
                    end
                end
            end
        end

        // Self-timed cycles count down and return to idle
        unique case (st_q)
            OLSS_IDLE: begin
            end
            OLSS_OTP: begin
                // One staged byte folded in per cycle; a target beyond
                // the control byte is dropped rather than wrapped
                if (pidx_q < 7'(OTP_BYTES)) begin
                    prog = svalid_q[pidx_q] && (ptgt < 8'(OTP_BYTES));
                    pidx_d = pidx_q + 7'h01;
                end
                // Latch drops in the first cycle, well before the end
                wel_d = 1'b0;
                tmr_d = tmr_q - CW'(1);
                if (tmr_q == CW'(1)) begin
                    st_d = OLSS_IDLE;
                end
            end
            OLSS_ERASE: begin
                // The array does the erase; only the timer lives here
                wel_d = 1'b0;
                tmr_d = tmr_q - CW'(1);
                if (tmr_q == CW'(1)) begin
                    st_d = OLSS_IDLE;
                end
            end
        endcase
    end

    // Register the sequencer; lock-down bits clear only at power-up reset,
    // and a low enable freezes every register of the group
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_q <= OLSS_IDLE;
            tmr_q <= '0;
            wel_q <= 1'b0;
            pidx_q <= 7'h00;
            pbase_q <= 7'h00;
            svalid_q <= '0;
            esub_q <= '0;
            o_erase_start <= 1'b0;
            for (int s = 0; s < SECTORS; s++) begin
                lock_q[s] <= LOCK_RESET;
            end
        end else if (i_ce) begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            wel_q <= wel_d;
            pidx_q <= pidx_d;
            pbase_q <= pbase_d;
            svalid_q <= svalid_d;
            esub_q <= esub_d;
            o_erase_start <= erase_d;
            for (int s = 0; s < SECTORS; s++) begin
                lock_q[s] <= lock_d[s];
            end
        end
    end

    // OTP store; programming only ever clears bits
    olss_otp_array #(.DEPTH(OTP_BYTES)) u_otp (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_prog(prog && i_ce),
        .i_idx(ptgt[6:0]),
        .i_data(stage_q[pidx_q]),
        .i_rd_idx(i_otp_rd_idx),
        .o_rd_data(o_otp_rd_data),
        .o_locked(otp_locked)
    );


    // Status outputs; busy is the state itself, so the flag drops in the
    // same cycle the timer runs out
    assign o_write_in_progress_flag = busy;
    assign o_write_enable_latch = wel_q;
    assign o_otp_locked = otp_locked;
    assign o_erase_subsector = esub_q;
    // Upper six bits read as zero whatever the host wrote there
    assign o_sector_lock_byte = {6'h00, lock_q[i_lock_rd_sector]};
endmodule

/* File: bench/olss_seq_sva.sv */
// Checker for the sequencer status and erase outputs
`timescale 1ns/1ps
module olss_seq_sva #(
    parameter int PP_CNT = 400,
    parameter int SSE_CNT = 400
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Watched outputs
    input wire logic o_write_in_progress_flag,
    input wire logic o_write_enable_latch,
    input wire logic o_otp_locked,
    input wire logic o_erase_start,
    input wire logic [olss_pkg::SUBSECT_W-1:0] o_erase_subsector,
    input wire logic [7:0] o_sector_lock_byte
);
    import olss_pkg::*;
    localparam int MIN_C = (PP_CNT < SSE_CNT) ? PP_CNT : SSE_CNT;
    localparam int MAX_C = (PP_CNT > SSE_CNT) ? PP_CNT : SSE_CNT;
    logic [31:0] busy_d;
    logic [31:0] busy_q;
    // Busy run length; long runs need a counter, not a repetition
    always_comb begin
        busy_d = o_write_in_progress_flag ? busy_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge i_clk) begin
        busy_q <= i_reset ? 32'h0 : busy_d;
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    sequence s_busy_start;
        $rose(o_write_in_progress_flag);
    endsequence
    sequence s_busy_end;
        $fell(o_write_in_progress_flag);
    endsequence
    property p_busy_needs_latch;
        s_busy_start |-> $past(o_write_enable_latch);
    endproperty
    a_busy_needs_latch: assert property (p_busy_needs_latch)
        else $error("busy started without write enable");
    property p_busy_len;
        s_busy_end |-> busy_q >= MIN_C - 1 && busy_q <= MAX_C + 1;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy length wrong");
    property p_busy_max;
        busy_q <= MAX_C + 1;
    endproperty
    a_busy_max: assert property (p_busy_max)
        else $error("busy too long");
    property p_latch_clear;
        s_busy_end |-> !o_write_enable_latch;
    endproperty
    a_latch_clear: assert property (p_latch_clear)
        else $error("latch still set at end of cycle");
    property p_refuse_busy;
        o_write_in_progress_flag && $past(o_write_in_progress_flag)
            |-> !$rose(o_write_enable_latch);
    endproperty
    a_refuse_busy: assert property (p_refuse_busy)
        else $error("enable taken while busy");
    property p_no_erase_busy;
        busy_q > 32'h3 |-> !o_erase_start;
    endproperty
    a_no_erase_busy: assert property (p_no_erase_busy)
        else $error("erase started while busy");
    property p_erase_pulse;
        o_erase_start |=> !o_erase_start ##1 $stable(o_erase_subsector);
    endproperty
    a_erase_pulse: assert property (p_erase_pulse)
        else $error("erase start not a single pulse");
    property p_erase_busy;
        o_erase_start |-> ##[0:3] o_write_in_progress_flag;
    endproperty
    a_erase_busy: assert property (p_erase_busy)
        else $error("erase without busy");
    property p_otp_sticky;
        o_otp_locked |=> o_otp_locked;
    endproperty
    a_otp_sticky: assert property (p_otp_sticky)
        else $error("otp lock released");
    property p_lock_upper;
        o_sector_lock_byte[7:2] == 6'h0;
    endproperty
    a_lock_upper: assert property (p_lock_upper)
        else $error("lock byte upper bits set");
endmodule
bind olss_sequencer olss_seq_sva #(.PP_CNT(PP_CNT), .SSE_CNT(SSE_CNT)) u_sva (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .o_write_in_progress_flag(o_write_in_progress_flag),
    .o_write_enable_latch(o_write_enable_latch),
    .o_otp_locked(o_otp_locked),
    .o_erase_start(o_erase_start),
    .o_erase_subsector(o_erase_subsector),
    .o_sector_lock_byte(o_sector_lock_byte)
);

/* File: bench/olss_host_model.sv */
// Host serial master model: link clock, select and data line
`timescale 1ns/1ps
module olss_host_model (
    // Link pins
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_serial_in_pin
);
    logic [7:0] data [0:79];
    // Idle: clock low, select high
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_serial_in_pin = 1'b0;
    end
    // One frame MSB first; link clock runs only while selected
    task automatic xfer(input logic [7:0] op, input logic [23:0] addr,
                        input int nbits);
        #7 o_cs_n = 1'b0;
        for (int k = 0; k < nbits; k++) begin
            if (k < 8) begin
                o_serial_in_pin = op[7 - k];
            end else if (k < 32) begin
                o_serial_in_pin = addr[31 - k];
            end else begin
                o_serial_in_pin = data[(k - 32) / 8][7 - (k % 8)];
            end
            #40 o_sclk = 1'b1;
            #40 o_sclk = 1'b0;
        end
        #40 o_cs_n = 1'b1;
        // Released line shows no stale bit
        o_serial_in_pin = ~o_serial_in_pin;
        #400;
    endtask
endmodule

/* File: bench/tb_top.sv */
// Testbench: host frames against the sequencer
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_top;
    import olss_pkg::*;
    logic i_clk;
    logic i_reset;
    logic [2:0] bp;
    logic ce;
    logic [5:0] rd_sec;
    logic [6:0] rd_idx;
    logic sclk, cs_n, sdi, write_in_progress_flag, write_enable_latch, locked, er_start;
    logic [SUBSECT_W-1:0] er_sub;
    logic [SUBSECT_W-1:0] last_sub;
    logic [7:0] lock_byte, otp_byte;
    int errors, comparisons, pulses;
    // System clock
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    olss_sequencer #(.PP_CNT(400), .SSE_CNT(400), .SECTORS(64)) DUT (
        .i_clk(i_clk), .i_reset(i_reset), .i_ce(ce),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_serial_in_pin(sdi),
        .i_block_protect_bits(bp),
        .o_write_in_progress_flag(write_in_progress_flag), .o_write_enable_latch(write_enable_latch),
        .o_otp_locked(locked),
        .o_erase_start(er_start), .o_erase_subsector(er_sub),
        .i_lock_rd_sector(rd_sec), .o_sector_lock_byte(lock_byte),
        .i_otp_rd_idx(rd_idx), .o_otp_rd_data(otp_byte)
    );
    olss_host_model host (
        .o_sclk(sclk), .o_cs_n(cs_n), .o_serial_in_pin(sdi)
    );
    // Erase pulse monitor
    always @(posedge i_clk) begin
        if (er_start === 1'b1) begin
            pulses++;
            last_sub = er_sub;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask
    task automatic send(input logic [7:0] op, input logic [23:0] a,
                        input int nbits);
        host.xfer(op, a, nbits);
        tick(6);
    endtask
    task automatic write_enable_instr();
        send(OP_WRITE_ENABLE, 24'h0, 8);
    endtask
    // Bounded wait for the timed cycle to end
    task automatic wait_idle();
        int n;
        n = 0;
        while (write_in_progress_flag !== 1'b0 && n < 1000) begin
            tick(1);
            n++;
        end
        if (n >= 1000) begin
            errors++;
            $display("unexpected at %0t: busy never ended", $time);
            test_done();
        end
    endtask
    task automatic otp_chk(input logic [6:0] idx, input logic [7:0] exp);
        rd_idx = idx;
        tick(2);
        `CHK(otp_byte, exp);
    endtask
    task automatic lock_chk(input logic [5:0] s, input logic [7:0] exp);
        rd_sec = s;
        #1;
        `CHK(lock_byte, exp);
    endtask
    initial begin
        i_reset = 1'b1;
        bp = 3'h0;
        ce = 1'b1;
        rd_sec = 6'h0;
        rd_idx = 7'h0;
        errors = 0;
        comparisons = 0;
        pulses = 0;
        repeat (6) @(posedge i_clk);
        #2 i_reset = 1'b0;
        tick(2);
        `CHK({write_in_progress_flag, write_enable_latch, locked}, 3'h0);
        otp_chk(7'h0, 8'hFF);
        // Erase refused without enable, then with a short frame
        send(OP_SMALL_ERASE, 24'h012345, 32);
        `CHK(write_in_progress_flag, 1'b0);
        // Enable low freezes the decode; it resumes once enable returns
        ce = 1'b0;
        write_enable_instr();
        `CHK(write_enable_latch, 1'b0);
        ce = 1'b1;
        tick(4);
        `CHK(write_enable_latch, 1'b1);
        send(OP_SMALL_ERASE, 24'h012345, 31);
        `CHK({write_in_progress_flag, write_enable_latch}, 2'h1);
        send(OP_SMALL_ERASE, 24'hC12345, 32);
        `CHK(write_in_progress_flag, 1'b1);
        `CHK(pulses, 1);
        `CHK(last_sub, 10'h012);
        // Frames during the cycle are refused
        host.data[0] = 8'h01;
        send(OP_LOCK_WRITE, 24'h050000, 40);
        lock_chk(6'h5, 8'h00);
        send(OP_SMALL_ERASE, 24'h013000, 32);
        wait_idle();
        `CHK(pulses, 1);
        `CHK(write_enable_latch, 1'b0);
        // OTP program, high address bits ignored
        write_enable_instr();
        host.data[0] = 8'hA5;
        host.data[1] = 8'h3C;
        send(OP_OTP_PROGRAM, 24'hFFFF80, 48);
        `CHK(write_in_progress_flag, 1'b1);
        wait_idle();
        `CHK(write_enable_latch, 1'b0);
        otp_chk(7'h0, 8'hA5);
        otp_chk(7'h1, 8'h3C);
        write_enable_instr();
        host.data[0] = 8'h0F;
        send(OP_OTP_PROGRAM, 24'h0, 47);
        `CHK({write_in_progress_flag, write_enable_latch}, 2'h1);
        send(OP_OTP_PROGRAM, 24'hFFFF81, 40);
        wait_idle();
        otp_chk(7'h1, 8'h0C);
        otp_chk(7'h0, 8'hA5);
        // Full frame plus one: last byte dropped, control byte locks
        for (int i = 0; i < 66; i++) begin
            host.data[i] = 8'hFF;
        end
        host.data[2] = 8'hF0;
        host.data[64] = 8'hFE;
        host.data[65] = 8'h00;
        write_enable_instr();
        send(OP_OTP_PROGRAM, 24'h0, 560);
        wait_idle();
        `CHK(locked, 1'b1);
        otp_chk(7'h0, 8'hA5);
        otp_chk(7'h2, 8'hF0);
        write_enable_instr();
        host.data[2] = 8'h00;
        send(OP_OTP_PROGRAM, 24'h0, 56);
        wait_idle();
        otp_chk(7'h2, 8'hF0);
        // Lock byte write: over-long frame refused, exact frame taken
        write_enable_instr();
        host.data[0] = 8'h01;
        send(OP_LOCK_WRITE, 24'h05ABCD, 41);
        lock_chk(6'h5, 8'h00);
        send(OP_LOCK_WRITE, 24'h05ABCD, 40);
        lock_chk(6'h5, 8'h01);
        `CHK({write_in_progress_flag, write_enable_latch}, 2'h0);
        write_enable_instr();
        send(OP_SMALL_ERASE, 24'h050000, 32);
        `CHK({write_in_progress_flag, write_enable_latch}, 2'h0);
        // Lock-down freezes the sector until reset
        write_enable_instr();
        host.data[0] = 8'h03;
        send(OP_LOCK_WRITE, 24'h060000, 40);
        write_enable_instr();
        host.data[0] = 8'h00;
        send(OP_LOCK_WRITE, 24'h060000, 40);
        lock_chk(6'h6, 8'h03);
        // Hardware protection blocks, then clear and erase
        bp = 3'h7;
        write_enable_instr();
        send(OP_SMALL_ERASE, 24'h001000, 32);
        `CHK(write_in_progress_flag, 1'b0);
        bp = 3'h0;
        write_enable_instr();
        send(OP_SMALL_ERASE, 24'h001000, 32);
        `CHK(pulses, 2);
        `CHK(last_sub, 10'h001);
        wait_idle();
        // Second reset mid-run releases frozen locks
        i_reset = 1'b1;
        tick(2);
        i_reset = 1'b0;
        tick(2);
        lock_chk(6'h6, 8'h00);
        test_done();
    end
endmodule
